/* File: hw/link_pkg.sv */
// shared constants, carriers and decoders of the host serial link
// assumes one 250 MHz core clock and synchronous active-high reset
package link_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int FAST_BAUD = 1_000_000;
  localparam int SLOW_BAUD = 250_000;
  localparam int FAST_BIT_CYC = CLK_HZ / FAST_BAUD;
  localparam int SLOW_BIT_CYC = CLK_HZ / SLOW_BAUD;
  localparam int CNT_W = 10;
  localparam int CLEAR_LOW_BITS = 12;
  localparam int ADDR_W = 6;
  localparam int FRAME_TYPE_BIT = 7;
  localparam int REQ_HI = 6;
  localparam int REQ_LO = 4;
  localparam int SIZE_HI = 2;
  localparam int SIZE_LO = 0;
  localparam int REG_HI_POS = 1;
  localparam int REG_LO_POS = 2;
  localparam int REG_ADDR_BYTES = 2;
  localparam int CRC_BYTES = 2;

  typedef enum logic [2:0] {
    REQ_SINGLE_READ = 3'h0, REQ_SINGLE_WRITE = 3'h1, REQ_STACK_READ = 3'h2,
    REQ_STACK_WRITE = 3'h3, REQ_BCAST_READ = 3'h4, REQ_BCAST_WRITE = 3'h5,
    REQ_BCAST_WRITE_REV = 3'h6, REQ_RESERVED = 3'h7
  } req_t;

  typedef struct packed {
    logic multidrop_en;
    logic stack_member_select;
    logic two_stop_en;
    logic debug_mode;
    logic slow_baud_sel;
    logic [7:0] tx_hold_off;
    logic [ADDR_W-1:0] dev_addr;
  } cfg_t;

  typedef struct packed {
    logic stop_error_flag;
    logic clear_detected_flag;
    logic waiting_to_send_debug;
    logic clear_during_send_debug;
  } fault_t;

  typedef struct packed {
    req_t req;
    logic has_addr;
    logic [ADDR_W-1:0] addr;
    logic [15:0] reg_addr;
    logic [3:0] data_count;
  } cmd_t;

  localparam fault_t FAULT_RESET = 4'h0;

  function automatic logic req_has_addr(req_t r);
    return r == REQ_SINGLE_READ || r == REQ_SINGLE_WRITE;
  endfunction

  function automatic logic req_is_read(req_t r);
    return r == REQ_SINGLE_READ || r == REQ_STACK_READ || r == REQ_BCAST_READ;
  endfunction

  function automatic logic [CNT_W-1:0] bit_cycles(logic debug_mode, logic slow_sel);
    return (debug_mode && slow_sel) ? CNT_W'(SLOW_BIT_CYC) : CNT_W'(FAST_BIT_CYC);
  endfunction
endpackage

/* File: hw/link_rx.sv */
// serial receiver: start edge, mid-bit sampling, stop check, long-low clear
// assumes rx_line synchronous to clk and bit_cyc stable during a byte
module link_rx #(
  parameter int CLEAR_BITS = link_pkg::CLEAR_LOW_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_line,
  input wire logic [link_pkg::CNT_W-1:0] bit_cyc,
  input wire logic flush,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic stop_err,
  output logic clear_seen
);
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_STOP = 3'b011, RX_WAIT = 3'b100
  } rx_state_t;
  typedef struct packed {
    rx_state_t st;
    logic [link_pkg::CNT_W-1:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic [link_pkg::CNT_W-1:0] low_cyc;
    logic [4:0] low_bits;
    logic valid;
    logic err;
    logic clr;
  } rx_t;
  rx_t q, d;
  logic bit_end;

  if (CLEAR_BITS <= 10 || CLEAR_BITS > 31) begin
    $error("CLEAR_BITS must lie in 11..31");
  end

  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.err = 1'b0;
    d.clr = 1'b0;
    bit_end = q.cnt == bit_cyc - 1'b1;
    d.cnt = bit_end ? '0 : q.cnt + 1'b1;
    unique case (q.st)
      RX_IDLE: begin
        d.cnt = '0;
        // RULE25 falling start edge
        if (!rx_line) d.st = RX_START;
      end
      RX_START: begin
        if (q.cnt == (bit_cyc >> 1)) begin
          d.cnt = '0;
          d.bitn = 3'h0;
          d.st = rx_line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (bit_end) begin
          // RULE25 centre sample, lsb first
          d.shreg = {rx_line, q.shreg[7:1]};
          d.bitn = q.bitn + 3'h1;
          if (q.bitn == 3'h7) d.st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (bit_end) begin
          // RULE3 one stop bit ends the byte
          d.valid = rx_line;
          // RULE4 stop sampled low
          d.err = !rx_line;
          d.st = rx_line ? RX_IDLE : RX_WAIT;
        end
      end
      RX_WAIT: if (rx_line) d.st = RX_IDLE;
      default: d.st = RX_WAIT;
    endcase
    // RULE15 clear seen in any state
    if (rx_line) begin
      d.low_cyc = '0;
      d.low_bits = '0;
    end else if (q.low_bits != 5'(CLEAR_BITS)) begin
      d.low_cyc = (q.low_cyc == bit_cyc - 1'b1) ? '0 : q.low_cyc + 1'b1;
      if (q.low_cyc == bit_cyc - 1'b1) begin
        d.low_bits = q.low_bits + 5'h1;
        if (q.low_bits == 5'(CLEAR_BITS - 1)) begin
          d.clr = 1'b1;
          d.st = RX_WAIT;
        end
      end
    end
    // flush waits for idle line, then hunts a fresh start
    if (flush) begin
      d.st = RX_WAIT;
      d.valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) q <= '0;
    else q <= d;
  end

  assign byte_valid = q.valid;
  assign byte_data = q.shreg;
  assign stop_err = q.err;
  assign clear_seen = q.clr;
endmodule

/* File: hw/link_tx.sv */
// serial transmitter: 8 data bits lsb first, one or two stop bits
// assumes start is a one-cycle pulse given only while idle
module link_tx (
  input wire logic clk,
  input wire logic srst,
  input wire logic [link_pkg::CNT_W-1:0] bit_cyc,
  input wire logic two_stop,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic abort,
  output logic tx_line,
  output logic done
);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_STOP1 = 3'b011, TX_STOP2 = 3'b100
  } tx_state_t;
  typedef struct packed {
    tx_state_t st;
    logic [link_pkg::CNT_W-1:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic line;
    logic done;
  } tx_t;
  tx_t q, d;
  logic bit_end;

  always_comb begin
    d = q;
    d.done = 1'b0;
    bit_end = q.cnt == bit_cyc - 1'b1;
    d.cnt = bit_end ? '0 : q.cnt + 1'b1;
    unique case (q.st)
      TX_IDLE: begin
        d.cnt = '0;
        d.line = 1'b1;
        if (start) begin
          d.shreg = data;
          d.line = 1'b0;
          d.st = TX_START;
        end
      end
      TX_START: begin
        if (bit_end) begin
          d.bitn = 3'h0;
          d.line = q.shreg[0];
          d.st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bit_end) begin
          d.bitn = q.bitn + 3'h1;
          d.shreg = q.shreg >> 1;
          d.line = (q.bitn == 3'h7) ? 1'b1 : q.shreg[1];
          if (q.bitn == 3'h7) d.st = TX_STOP1;
        end
      end
      TX_STOP1: begin
        if (bit_end) begin
          // RULE8 second stop bit on request
          d.st = two_stop ? TX_STOP2 : TX_IDLE;
          d.done = !two_stop;
        end
      end
      TX_STOP2: begin
        if (bit_end) begin
          d.st = TX_IDLE;
          d.done = 1'b1;
        end
      end
      default: d.st = TX_IDLE;
    endcase
    // RULE7 clear cuts the byte short
    if (abort) begin
      d.st = TX_IDLE;
      d.line = 1'b1;
      d.done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign tx_line = q.line;
  assign done = q.done;
endmodule

/* File: hw/host_uart.sv */
// base-device host serial link: framing, clear recovery, response turnaround
// assumes the core supplies response bytes on request and reads faults as ports
// Function
// RULE1: multidrop bit set means standalone unit; clear means base or stack in chain.
// RULE2: chain devices carry a six-bit address, so at most 64 per chain.
// RULE3: bytes are 8-N-1: low start, eight data bits, one stop, no parity.
// RULE4: a stop bit sampled low sets the stop error flag.
// RULE5: 1 Mbps by default; 250 kbps only with debug mode enabled.
// RULE6: a stack member keeps its transmitter off; only the base answers the host.
// RULE7: half duplex: received bytes ignored while sending, but clear aborts at once.
// RULE8: two-stop enable adds a second stop bit; receiver takes one or more.
// RULE9: stack members use the two-stop enable to size inter-frame gaps.
// RULE10: after the last received bit, wait hold-off bit periods before sending.
// RULE11: host that talks over a response must follow with a clear.
// RULE12: clear flushes the receiver; the next byte starts a new frame.
// RULE13: clear sets the clear-detected flag and also the stop error flag.
// RULE14: host holds clear under its maximum and waits the minimum afterwards.
// RULE15: clear acts on the receive pin only and is accepted at any time.
// RULE16: wake tone flushes receiver; sets clear flag, plus stop error when active.
// RULE17: clear during a read response discards it and sets a debug bit by timing.
// RULE18: in multidrop the host sends a clear before every command frame.
// RULE19: send only in answer to a received read command.
// RULE20: host waits for all responses or a timeout before the next command.
// RULE21: stack read and write are answered only by stack members.
// RULE22: frame order: init, address, register high, low, data, checksum high then low.
// RULE23: init bit 7 marks command; bits 6..4 request; bits 2..0 count minus one.
// RULE24: address byte only in single-device commands; always in responses.
// RULE25: receiver finds the start edge and samples each bit at its centre.
module host_uart #(
  parameter int CLEAR_BITS = link_pkg::CLEAR_LOW_BITS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_enable,
  input wire link_pkg::cfg_t cfg,
  input wire link_pkg::fault_t fault_clear,
  input wire logic wake_tone,
  input wire logic asleep,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready,
  output logic resp_abort,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_sof,
  output logic cmd_valid,
  output link_pkg::cmd_t cmd,
  output logic cmd_for_me,
  output link_pkg::fault_t faults,
  output logic frame_gap_busy
);
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00, RS_HOLD = 2'b01, RS_WANT = 2'b10, RS_SEND = 2'b11
  } resp_state_t;

  typedef struct packed {
    resp_state_t rs;
    logic in_frame;
    logic [3:0] pos;
    logic [3:0] left;
    link_pkg::cmd_t cmd;
    logic [link_pkg::CNT_W-1:0] hold_cyc;
    logic [7:0] hold_bits;
    logic last;
    logic tx_start;
    logic [7:0] tx_data;
    logic tx_abort;
    link_pkg::fault_t faults;
    logic rx_byte_valid;
    logic [7:0] rx_byte;
    logic rx_sof;
    logic cmd_valid;
    logic cmd_for_me;
    logic resp_ready;
    logic resp_abort;
    logic tx_enable;
    logic [link_pkg::CNT_W-1:0] gap_cyc;
    logic [1:0] gap_bits;
    logic gap_busy;
  } state_t;

  state_t s_q, s_d;
  logic [link_pkg::CNT_W-1:0] bit_cyc;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_stop_err;
  logic rx_clear;
  logic tx_done;
  logic flush_ev;
  logic [3:0] idx;
  logic [3:0] ri;
  logic [3:0] count;
  link_pkg::req_t req;
  logic has_addr;

  if (CLEAR_BITS <= 10 || CLEAR_BITS > 31) begin
    $error("CLEAR_BITS must lie in 11..31");
  end

  // decides whether a finished command frame targets this device
  function automatic logic addressed(link_pkg::cmd_t c, link_pkg::cfg_t g);
    logic hit;
    hit = 1'b0;
    unique case (c.req)
      link_pkg::REQ_SINGLE_READ, link_pkg::REQ_SINGLE_WRITE: hit = c.addr == g.dev_addr;
      link_pkg::REQ_STACK_READ, link_pkg::REQ_STACK_WRITE: hit = g.stack_member_select && !g.multidrop_en;
      link_pkg::REQ_BCAST_READ, link_pkg::REQ_BCAST_WRITE: hit = 1'b1;
      link_pkg::REQ_BCAST_WRITE_REV: hit = !g.multidrop_en;
      link_pkg::REQ_RESERVED: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // RULE5 slow rate gated by debug mode
  assign bit_cyc = link_pkg::bit_cycles(cfg.debug_mode, cfg.slow_baud_sel);

  link_rx #(
    .CLEAR_BITS(CLEAR_BITS)
  ) u_rx (
    .clk(clk),
    .srst(srst),
    .rx_line(rx_line),
    .bit_cyc(bit_cyc),
    .flush(wake_tone),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .stop_err(rx_stop_err),
    .clear_seen(rx_clear)
  );

  link_tx u_tx (
    .clk(clk),
    .srst(srst),
    .bit_cyc(bit_cyc),
    .two_stop(cfg.two_stop_en),
    .start(s_q.tx_start),
    .data(s_q.tx_data),
    .abort(s_q.tx_abort),
    .tx_line(tx_line),
    .done(tx_done)
  );

  assign flush_ev = rx_clear || wake_tone;
  assign req = link_pkg::req_t'(rx_data[link_pkg::REQ_HI:link_pkg::REQ_LO]);
  assign has_addr = link_pkg::req_has_addr(req);
  assign count = {1'b0, rx_data[link_pkg::SIZE_HI:link_pkg::SIZE_LO]} + 4'h1;
  assign idx = s_q.pos + 4'h1;
  assign ri = idx - {3'h0, s_q.cmd.has_addr};

  always_comb begin
    s_d = s_q;
    s_d.rx_byte_valid = 1'b0;
    s_d.rx_sof = 1'b0;
    s_d.cmd_valid = 1'b0;
    s_d.tx_start = 1'b0;
    s_d.tx_abort = 1'b0;
    s_d.resp_abort = 1'b0;
    // RULE1 chain side off in multidrop
    // RULE6 stack member keeps transmitter off
    s_d.tx_enable = cfg.multidrop_en || !cfg.stack_member_select;

    // software clear first so a same-cycle event still lands
    s_d.faults = s_q.faults & ~fault_clear;
    // RULE4 missing stop bit
    if (rx_stop_err) s_d.faults.stop_error_flag = 1'b1;

    if (flush_ev) begin
      // RULE13 clear raises both flags
      if (rx_clear) begin
        s_d.faults.clear_detected_flag = 1'b1;
        s_d.faults.stop_error_flag = 1'b1;
      end
      // RULE16 wake tone flags by mode
      if (wake_tone) begin
        s_d.faults.clear_detected_flag = 1'b1;
        if (!asleep) s_d.faults.stop_error_flag = 1'b1;
      end
      // RULE12 next byte is start of frame
      s_d.in_frame = 1'b0;
      s_d.pos = 4'h0;
      s_d.left = 4'h0;
      // RULE17 pending answer dropped, timing noted
      if (s_q.rs == RS_HOLD) s_d.faults.waiting_to_send_debug = 1'b1;
      if (s_q.rs == RS_WANT || s_q.rs == RS_SEND) s_d.faults.clear_during_send_debug = 1'b1;
      // RULE7 clear aborts the transfer
      if (s_q.rs != RS_IDLE) begin
        s_d.resp_abort = 1'b1;
        s_d.tx_abort = 1'b1;
      end
      s_d.rs = RS_IDLE;
      s_d.resp_ready = 1'b0;
    end else if (rx_valid && s_q.rs == RS_IDLE) begin
      // RULE7 bytes only heard when not answering
      s_d.rx_byte_valid = 1'b1;
      s_d.rx_byte = rx_data;
      if (!s_q.in_frame) begin
        // RULE23 command bit and length
        if (rx_data[link_pkg::FRAME_TYPE_BIT]) begin
          s_d.rx_sof = 1'b1;
          s_d.in_frame = 1'b1;
          s_d.pos = 4'h0;
          s_d.cmd = '0;
          s_d.cmd.req = req;
          // RULE24 address byte only for single device
          s_d.cmd.has_addr = has_addr;
          s_d.cmd.data_count = count;
          // RULE22 fixed byte order after init
          s_d.left = 4'(has_addr) + 4'(link_pkg::REG_ADDR_BYTES) + count + 4'(link_pkg::CRC_BYTES);
        end
      end else begin
        s_d.pos = idx;
        s_d.left = s_q.left - 4'h1;
        // RULE2 six-bit device address
        if (s_q.cmd.has_addr && idx == 4'h1) s_d.cmd.addr = rx_data[link_pkg::ADDR_W-1:0];
        // RULE22 register address high then low
        if (ri == 4'(link_pkg::REG_HI_POS)) s_d.cmd.reg_addr[15:8] = rx_data;
        if (ri == 4'(link_pkg::REG_LO_POS)) s_d.cmd.reg_addr[7:0] = rx_data;
        if (s_q.left == 4'h1) begin
          s_d.in_frame = 1'b0;
          s_d.cmd_valid = 1'b1;
          // RULE21 stack commands need stack member bit
          s_d.cmd_for_me = addressed(s_d.cmd, cfg);
          // RULE9 inter-frame gap from stop count
          s_d.gap_busy = 1'b1;
          s_d.gap_cyc = '0;
          s_d.gap_bits = cfg.two_stop_en ? 2'h2 : 2'h1;
          // RULE19 only a read addressed here answers
          if (addressed(s_d.cmd, cfg) && link_pkg::req_is_read(s_d.cmd.req) && s_d.tx_enable) begin
            s_d.rs = RS_HOLD;
            s_d.hold_cyc = '0;
            s_d.hold_bits = 8'h00;
          end
        end
      end
    end else begin
      unique case (s_q.rs)
        RS_IDLE: s_d.resp_ready = 1'b0;
        RS_HOLD: begin
          // RULE10 hold-off in bit periods
          if (s_q.hold_bits == cfg.tx_hold_off) begin
            s_d.rs = RS_WANT;
            s_d.resp_ready = 1'b1;
          end else if (s_q.hold_cyc == bit_cyc - 1'b1) begin
            s_d.hold_cyc = '0;
            s_d.hold_bits = s_q.hold_bits + 8'h01;
          end else begin
            s_d.hold_cyc = s_q.hold_cyc + 1'b1;
          end
        end
        RS_WANT: begin
          if (resp_valid && s_q.resp_ready) begin
            s_d.tx_start = 1'b1;
            s_d.tx_data = resp_data;
            s_d.last = resp_last;
            s_d.resp_ready = 1'b0;
            s_d.rs = RS_SEND;
          end
        end
        RS_SEND: begin
          if (tx_done) begin
            s_d.rs = s_q.last ? RS_IDLE : RS_WANT;
            s_d.resp_ready = !s_q.last;
          end
        end
      endcase
    end

    // gap timer only runs between frames, never blocks the host
    if (s_q.gap_busy && !(rx_valid && s_q.left == 4'h1)) begin
      if (s_q.gap_cyc == bit_cyc - 1'b1) begin
        s_d.gap_cyc = '0;
        s_d.gap_bits = s_q.gap_bits - 2'h1;
        if (s_q.gap_bits == 2'h1) s_d.gap_busy = 1'b0;
      end else begin
        s_d.gap_cyc = s_q.gap_cyc + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.faults <= link_pkg::FAULT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_enable = s_q.tx_enable;
  assign resp_ready = s_q.resp_ready;
  assign resp_abort = s_q.resp_abort;
  assign rx_byte_valid = s_q.rx_byte_valid;
  assign rx_byte = s_q.rx_byte;
  assign rx_sof = s_q.rx_sof;
  assign cmd_valid = s_q.cmd_valid;
  assign cmd = s_q.cmd;
  assign cmd_for_me = s_q.cmd_for_me;
  assign faults = s_q.faults;
  assign frame_gap_busy = s_q.gap_busy;
endmodule

/* File: test/host_model.sv */
// host controller model: drives the serial receive pin, decodes the transmit pin
// assumes callers start just after a clock edge; BIT is the bit period in cycles
module host_model #(
  parameter int BIT = 250
) (
  input wire logic clk,
  output logic rx_line,
  input wire logic tx_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rx_line = 1'b1;

  // level for n cycles, then just past the edge again
  task automatic put_bit(input logic v, input int n);
    rx_line = v;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send_byte(input logic [7:0] b, input logic stop);
    put_bit(1'b0, BIT);
    for (int i = 0; i < 8; i++) put_bit(b[i], BIT);
    put_bit(stop, BIT);
    if (!stop) put_bit(1'b1, BIT);
  endtask

  task automatic send_clear(input int bits);
    put_bit(1'b0, bits * BIT);
    put_bit(1'b1, 2 * BIT);
  endtask

  // waits for the answer under a bound
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int i;
    ok = 1'b0;
    b = 8'h00;
    for (i = 0; i < 20 * BIT && tx_line !== 1'b0; i++) @(posedge clk);
    if (tx_line !== 1'b0) return;
    repeat (BIT / 2) @(posedge clk);
    ok = tx_line === 1'b0;
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = tx_line;
    end
    // both stop periods must read high
    repeat (BIT) @(posedge clk);
    ok = ok && tx_line === 1'b1;
    repeat (BIT) @(posedge clk);
    ok = ok && tx_line === 1'b1;
  endtask
endmodule

/* File: test/host_uart_checker.sv */
// port-level checker for the host serial link
// assumes one clock domain with synchronous active-high reset
module host_uart_checker #(
  parameter int CLEAR_BITS = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tx_line,
  input wire logic tx_enable,
  input wire link_pkg::cfg_t cfg,
  input wire link_pkg::fault_t fault_clear,
  input wire logic wake_tone,
  input wire logic asleep,
  input wire logic resp_valid,
  input wire logic resp_last,
  input wire logic resp_ready,
  input wire logic resp_abort,
  input wire logic [7:0] rx_byte,
  input wire logic rx_sof,
  input wire logic cmd_valid,
  input wire link_pkg::cmd_t cmd,
  input wire logic cmd_for_me,
  input wire link_pkg::fault_t faults
);
  logic armed_q;
  logic armed_d;
  logic rd;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // armed from an accepted read until its last byte or an abort
  always_comb begin
    rd = cmd.req inside {link_pkg::REQ_SINGLE_READ, link_pkg::REQ_STACK_READ, link_pkg::REQ_BCAST_READ};
    armed_d = armed_q;
    if (cmd_valid && cmd_for_me && rd && tx_enable) armed_d = 1'b1;
    else if (resp_abort || (resp_valid && resp_ready && resp_last)) armed_d = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) armed_q <= 1'b0;
    else armed_q <= armed_d;
  end

  a_stack_tx_off: assert property ((cfg.stack_member_select && !cfg.multidrop_en) [*2] |-> !tx_enable)
    else $error("stack member transmitter enabled");
  a_no_unsolicited: assert property ($rose(resp_ready) |-> armed_q)
    else $error("response requested without a read command");
  a_stack_members: assert property (cmd_valid && !cfg.stack_member_select &&
      cmd.req inside {link_pkg::REQ_STACK_READ, link_pkg::REQ_STACK_WRITE} |-> !cmd_for_me)
    else $error("stack command taken by non member");
  a_reserved_dead: assert property (cmd_valid && cmd.req == link_pkg::REQ_RESERVED |-> !cmd_for_me)
    else $error("reserved request accepted");
  a_single_addr: assert property (cmd_valid && cmd.req inside {link_pkg::REQ_SINGLE_READ, link_pkg::REQ_SINGLE_WRITE}
      |-> cmd.has_addr && cmd_for_me == (cmd.addr == cfg.dev_addr))
    else $error("single device address mismatch");
  a_count_range: assert property (cmd_valid |-> cmd.data_count inside {[1:8]})
    else $error("data count out of range");
  a_start_bit: assert property (resp_valid && resp_ready |-> ##2 !tx_line [*8])
    else $error("start bit missing after byte taken");
  a_abort_idle: assert property (resp_abort |=> tx_line [*8])
    else $error("transmit line not idle after abort");
  a_flag_sticky: assert property (faults.stop_error_flag && !fault_clear.stop_error_flag
      |=> faults.stop_error_flag)
    else $error("stop error flag lost");
  a_wake_flag: assert property (wake_tone && asleep |-> ##[1:8] faults.clear_detected_flag)
    else $error("wake tone left clear flag low");
  a_sof_init: assert property (rx_sof |-> rx_byte[7])
    else $error("start of frame without command bit");

  cover property (cmd_valid && cmd_for_me);
  cover property (resp_abort);
  cover property ($rose(faults.clear_detected_flag));
endmodule

bind host_uart host_uart_checker #(.CLEAR_BITS(CLEAR_BITS)) host_uart_checker_inst (
  .clk(clk), .srst(srst), .tx_line(tx_line), .tx_enable(tx_enable), .cfg(cfg), .fault_clear(fault_clear),
  .wake_tone(wake_tone), .asleep(asleep), .resp_valid(resp_valid), .resp_last(resp_last),
  .resp_ready(resp_ready), .resp_abort(resp_abort), .rx_byte(rx_byte), .rx_sof(rx_sof),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_for_me(cmd_for_me), .faults(faults));

/* File: test/testbench.sv */
// self-checking bench for the host serial link
// assumes host_model speaks at the fast bit rate of 250 core cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  link_pkg::cfg_t cfg = '0;
  link_pkg::fault_t fault_clear = '0;
  logic wake_tone = 1'b0;
  logic asleep = 1'b0;
  logic resp_valid = 1'b0;
  logic [7:0] resp_data = 8'h00;
  logic resp_last = 1'b0;
  logic rx_line, tx_line, tx_enable, resp_ready, resp_abort, rx_byte_valid, rx_sof, cmd_valid, cmd_for_me, gap_busy;
  logic [7:0] rx_byte;
  link_pkg::cmd_t cmd;
  link_pkg::fault_t faults;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic [7:0] got;
  logic ok;

  always #2 clk = ~clk;

  host_uart host_uart_inst (.clk(clk), .srst(srst), .rx_line(rx_line), .tx_line(tx_line), .tx_enable(tx_enable),
    .cfg(cfg), .fault_clear(fault_clear), .wake_tone(wake_tone), .asleep(asleep), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_last(resp_last), .resp_ready(resp_ready), .resp_abort(resp_abort),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_sof(rx_sof), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_for_me(cmd_for_me), .faults(faults), .frame_gap_busy(gap_busy));
  host_model host_model_inst (.clk(clk), .rx_line(rx_line), .tx_line(tx_line));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // 0 command done, 1 byte wanted, 2 response dropped
  task automatic wait_on(input int which, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge clk);
      if ((which == 0 && cmd_valid === 1'b1) || (which == 1 && resp_ready === 1'b1)) break;
      if (which == 2 && resp_abort === 1'b1) break;
    end
    if (cnt >= lim) begin
      miscompares++;
      $display("BAD t=%0t wait=%h lim=%h", $time, which, lim);
      complete_run();
    end
  endtask

  task automatic send_frame(input logic [7:0] f [$]);
    foreach (f[i]) host_model_inst.send_byte(f[i], 1'b1);
  endtask

  task automatic clr_flags();
    fault_clear = 4'hF;
    @(posedge clk);
    #1 fault_clear = 4'h0;
    @(posedge clk);
    #1 check(faults, 4'h0);
  endtask

  task automatic wake(input logic sl, input logic [3:0] e);
    asleep = sl;
    wake_tone = 1'b1;
    @(posedge clk);
    #1 wake_tone = 1'b0;
    repeat (8) @(posedge clk);
    #1 check(faults, e);
    clr_flags();
  endtask

  // byte offered just after the edge that showed ready high
  task automatic answer(input logic [7:0] b);
    #1 resp_valid = 1'b1;
    resp_data = b;
    resp_last = 1'b1;
    @(posedge clk);
    #1 resp_valid = 1'b0;
    resp_last = 1'b0;
    host_model_inst.recv_byte(got, ok);
    #1 check(ok, 1'b1);
    check(got, b);
  endtask

  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    cfg.two_stop_en = 1'b1;
    cfg.tx_hold_off = 8'h04;
    cfg.dev_addr = 6'h05;
    cfg.slow_baud_sel = 1'b1; // ignored without debug mode
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    @(posedge clk);
    #1 check(tx_line, 1'b1);
    check(faults, 4'h0);
    check(tx_enable, 1'b1);
    cfg.stack_member_select = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(tx_enable, 1'b0);
    cfg.multidrop_en = 1'b1;
    repeat (2) @(posedge clk);
    #1 check(tx_enable, 1'b1);
    cfg.multidrop_en = 1'b0;
    cfg.stack_member_select = 1'b0;
    $display("test config done");

    fork
      send_frame('{8'h80, 8'h05, 8'h12, 8'h34, 8'h00, 8'hC3, 8'h3C});
      begin
        wait_on(0, 20000, n);
        check(cmd.req, link_pkg::REQ_SINGLE_READ);
        check({cmd.has_addr, cmd.addr}, 7'h45);
        check(cmd.reg_addr, 16'h1234);
        check(cmd.data_count, 4'h1);
        check(cmd_for_me, 1'b1);
        check(gap_busy, 1'b1);
        check({rx_byte_valid, rx_byte}, 9'h13C);
        wait_on(1, 1100, n);
        check(n >= 990 && n <= 1006, 1'b1);
        check(gap_busy, 1'b0);
      end
    join
    answer(8'h5A);
    $display("test single read done");

    send_frame('{8'h80, 8'h05});
    host_model_inst.send_clear(13);
    check(faults.clear_detected_flag, 1'b1);
    check(faults.stop_error_flag, 1'b1);
    clr_flags();
    fork
      send_frame('{8'hA0, 8'h12, 8'h34, 8'h00, 8'hC3, 8'h3C});
      begin
        wait_on(0, 18000, n);
        check(cmd.req, link_pkg::REQ_STACK_READ);
        check(cmd.has_addr, 1'b0);
        check(cmd_for_me, 1'b0);
      end
    join
    repeat (1500) @(posedge clk);
    #1 check(resp_ready, 1'b0);
    $display("test clear and stack read done");

    host_model_inst.send_byte(8'h00, 1'b0);
    check(faults, 4'h8);
    clr_flags();
    wake(1'b1, 4'h4);
    wake(1'b0, 4'hC);
    $display("test stop error and wake done");

    cfg.tx_hold_off = 8'h14;
    fork
      send_frame('{8'h80, 8'h05, 8'hAB, 8'hCD, 8'h00, 8'hC3, 8'h3C});
      wait_on(0, 20000, n);
    join
    fork
      host_model_inst.send_clear(13);
      wait_on(2, 3500, n);
    join
    check(faults, 4'hE);
    check(resp_ready, 1'b0);
    check(tx_line, 1'b1);
    clr_flags();
    $display("test clear during hold done");
    complete_run();
  end
endmodule
